// ===== rtl/dnh_pkg.sv
// Constants and carrier types shared by the oscillator bank and hop selector.
package dnh_pkg;

	localparam int NUM_OSC = 4;
	localparam int NUM_PATH = 2;
	localparam int SEL_W = 2;
	localparam int FREQ_W = 32;
	localparam int PHASE_W = 16;
	localparam int RDIV_W = 16;
	localparam int SAMPLE_W = 12;
	localparam int RESID_W = 19;
	localparam int PROD_W = FREQ_W + RDIV_W;

	// Pin change to mixer, in clock cycles, within the approximate 45 to 68 window.
	localparam int HOP_LAT_CYC = 45;
	localparam int HOP_SYNC_STAGES = 2;
	// Converter sample to mixer, in clock cycles.
	localparam int ADC_LAT_CYC = 37;
	// Step of the rational mode is the clock over 64 times the divider: 2^32 / 64 = 2^26.
	localparam int RDIV_SHIFT = 26;
	localparam logic [PROD_W:0] RND_HALF = 49'h0_0000_0200_0000;
	localparam logic [PROD_W:0] RND_KEEP = 49'h1_FFFF_FC00_0000;

	localparam logic [SEL_W-1:0] SEL_RST = 2'h0;
	localparam logic [FREQ_W-1:0] ACC_RST = 32'h0000_0000;
	localparam logic [RDIV_W-1:0] RDIV_BASIC = 16'h0000;
	localparam logic SRC_PINS = 1'b1;
	localparam logic [6:0] UP_MAX = 7'h7f;

	typedef struct packed {
		logic [NUM_OSC-1:0][FREQ_W-1:0] freq;
		logic [NUM_OSC-1:0][PHASE_W-1:0] phase;
	} dnh_path_cfg_t;

	typedef struct packed {
		logic msb;
		logic lsb;
	} dnh_hop_pins_t;

	typedef struct packed {
		logic [FREQ_W-1:0] inc;
		logic signed [RESID_W-1:0] resid;
	} dnh_step_t;

endpackage : dnh_pkg

// ===== rtl/dnh_nco_bank.sv
// Oscillator bank with fast hop selection and phase synchronization for two paths.
//
// Operation
// RULE_01 - Four independently programmed oscillators per path.
// RULE_02 - All accumulators advance every clock, selected or not.
// RULE_03 - Selection follows hop pin changes, asynchronously sampled.
// RULE_04 - Hop about 45 cycles, sample 37 cycles.
// RULE_05 - Source bit picks pins or soft field.
// RULE_06 - Selector is unsigned index, MSB upper.
// RULE_07 - Divider zero: frequency is word times clock/2^32.
// RULE_08 - Word wraps modulo 2^32, sign agnostic.
// RULE_09 - Word rewrite needs resynchronization for determinism.
// RULE_10 - Nonzero divider: exact steps of clock/(64*divider).
// RULE_11 - Software writes only integer divider values.
// RULE_12 - Software avoids divider values above 8192.
// RULE_13 - Phase offset left-justified, added to accumulator.
// RULE_14 - Software resynchronizes after any word change.
// RULE_15 - Sync from link init or reference pulse.
// RULE_16 - Link sync usable in every encoding mode.
// RULE_17 - Software programs, then enables link-init sync.
// RULE_18 - Align oscillators on link sync release high.
// RULE_19 - Armed with reference low, one pulse syncs.
// RULE_20 - Armed, next reference rising edge syncs.
// RULE_21 - Sync clears all accumulators on one clock.
`timescale 1ns/100ps
module dnh_nco_bank
	import dnh_pkg::*;
#(
	parameter int HOP_LAT = HOP_LAT_CYC,
	parameter int ADC_LAT = ADC_LAT_CYC
) (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic rstn_i,
	// Hop pins from the external logic device.
	input wire logic hop_pin_a_lsb_i,
	input wire logic hop_pin_a_msb_i,
	input wire logic hop_pin_b_lsb_i,
	input wire logic hop_pin_b_msb_i,
	// Selection settings.
	input wire logic select_source_i,
	input wire logic [SEL_W-1:0] soft_select_a_i,
	input wire logic [SEL_W-1:0] soft_select_b_i,
	// Oscillator settings.
	input wire dnh_path_cfg_t cfg_a_i,
	input wire dnh_path_cfg_t cfg_b_i,
	input wire logic [RDIV_W-1:0] rational_divider_i,
	// Synchronization controls and signals.
	input wire logic sync_on_link_init_i,
	input wire logic sync_on_next_reference_i,
	input wire logic link_enable_i,
	input wire logic link_sync_n_i,
	input wire logic reference_i,
	// Converter samples.
	input wire logic [SAMPLE_W-1:0] sample_i,
	// Mixer side.
	output logic [FREQ_W-1:0] phase_a_o,
	output logic [FREQ_W-1:0] phase_b_o,
	output logic [SEL_W-1:0] sel_a_o,
	output logic [SEL_W-1:0] sel_b_o,
	output logic [SAMPLE_W-1:0] sample_o,
	// Status.
	output logic sync_armed_o,
	output logic sync_event_o
);

	localparam int HOP_PIPE = HOP_LAT - HOP_SYNC_STAGES - 1;

	function automatic dnh_step_t acc_step(input logic [FREQ_W-1:0] freq,
		input logic [RDIV_W-1:0] rdiv, input logic signed [RESID_W-1:0] resid);
		logic [PROD_W-1:0] num;
		logic [PROD_W:0] rnd;
		logic signed [PROD_W+1:0] err;
		logic signed [RESID_W-1:0] r;
		logic signed [RESID_W-1:0] lim;
		dnh_step_t s;
		num = PROD_W'(freq) * PROD_W'(rdiv);
		rnd = {1'b0, num} + RND_HALF;
		err = $signed({1'b0, rnd & RND_KEEP}) - $signed({2'b00, num});
		lim = $signed({3'b000, rdiv});
		r = resid + RESID_W'(err);
		s.inc = freq;
		s.resid = r;
		if (rdiv == RDIV_BASIC) begin
			s.resid = '0;
		end else if (r >= lim) begin
			s.resid = r - lim;
			s.inc = freq + FREQ_W'(1);
		end else if (r < 0) begin
			s.resid = r + lim;
			s.inc = freq - FREQ_W'(1);
		end
		return s;
	endfunction : acc_step

	////////////////////////////////////////////////////////////////////////////////
	// Synchronization triggers.

	logic link_sync_q_r;
	logic ref_q_r;
	logic arm_q_r;
	logic armed_r;
	logic link_fire;
	logic ref_fire;
	logic sync_evt;

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			link_sync_q_r <= 1'b1;
			ref_q_r <= 1'b0;
			arm_q_r <= 1'b0;
		end else begin
			link_sync_q_r <= link_sync_n_i;
			ref_q_r <= reference_i;
			arm_q_r <= sync_on_next_reference_i;
		end
	end

	// Release of the link sync aligns the bank in any encoding mode.
	assign link_fire = sync_on_link_init_i && link_enable_i && link_sync_n_i
		&& !link_sync_q_r; // see RULE_16 see RULE_18
	assign ref_fire = armed_r && reference_i && !ref_q_r; // see RULE_19 see RULE_20
	assign sync_evt = link_fire || ref_fire; // see RULE_15

	// Arming on the rising edge of the arm bit wins over a firing in the same cycle.
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			armed_r <= 1'b0;
		end else if (sync_on_next_reference_i && !arm_q_r) begin
			armed_r <= 1'b1; // see RULE_20
		end else if (ref_fire || !sync_on_next_reference_i) begin
			armed_r <= 1'b0; // see RULE_19
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sync_event_o <= 1'b0;
			sync_armed_o <= 1'b0;
		end else begin
			sync_event_o <= sync_evt;
			sync_armed_o <= armed_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Hop selection.

	dnh_hop_pins_t pins [NUM_PATH];
	logic [SEL_W-1:0] soft_sel [NUM_PATH];
	logic [SEL_W-1:0] sync1_r [NUM_PATH];
	logic [SEL_W-1:0] sync2_r [NUM_PATH];
	logic [SEL_W-1:0] sel_now [NUM_PATH];
	logic [HOP_PIPE-1:0][SEL_W-1:0] hop_pipe_r [NUM_PATH];
	logic [SEL_W-1:0] sel_q [NUM_PATH];

	assign pins[0] = '{msb: hop_pin_a_msb_i, lsb: hop_pin_a_lsb_i};
	assign pins[1] = '{msb: hop_pin_b_msb_i, lsb: hop_pin_b_lsb_i};
	assign soft_sel[0] = soft_select_a_i;
	assign soft_sel[1] = soft_select_b_i;

	genvar p;
	genvar k;
	generate
		for (p = 0; p < NUM_PATH; p++) begin : g_sel
			// Pins arrive with no relation to the clock, so they pass a two-stage synchronizer.
			always_ff @(posedge mclk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					sync1_r[p] <= SEL_RST;
					sync2_r[p] <= SEL_RST;
				end else begin
					sync1_r[p] <= {pins[p].msb, pins[p].lsb}; // see RULE_03 see RULE_06
					sync2_r[p] <= sync1_r[p];
				end
			end

			assign sel_now[p] = (select_source_i == SRC_PINS) ? sync2_r[p]
				: soft_sel[p]; // see RULE_05 see RULE_06

			always_ff @(posedge mclk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					hop_pipe_r[p] <= '0;
				end else begin
					hop_pipe_r[p] <= {hop_pipe_r[p][HOP_PIPE-2:0], sel_now[p]}; // see RULE_04
				end
			end
			assign sel_q[p] = hop_pipe_r[p][HOP_PIPE-1];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Phase accumulators.

	dnh_path_cfg_t cfg [NUM_PATH];
	logic [NUM_OSC-1:0][FREQ_W-1:0] acc_r [NUM_PATH];
	logic signed [RESID_W-1:0] resid_r [NUM_PATH][NUM_OSC];
	dnh_step_t step [NUM_PATH][NUM_OSC];
	logic [FREQ_W-1:0] phase_nxt [NUM_PATH];

	assign cfg[0] = cfg_a_i;
	assign cfg[1] = cfg_b_i;

	generate
		for (p = 0; p < NUM_PATH; p++) begin : g_path
			for (k = 0; k < NUM_OSC; k++) begin : g_osc
				assign step[p][k] = acc_step(cfg[p].freq[k], rational_divider_i,
					resid_r[p][k]); // see RULE_07 see RULE_10
				// Every oscillator runs each clock; sync restarts the whole bank together.
				always_ff @(posedge mclk_i or negedge rstn_i) begin
					if (!rstn_i) begin
						acc_r[p][k] <= ACC_RST;
						resid_r[p][k] <= '0;
					end else if (sync_evt) begin
						acc_r[p][k] <= ACC_RST; // see RULE_21 see RULE_09
						resid_r[p][k] <= '0;
					end else begin
						acc_r[p][k] <= acc_r[p][k] + step[p][k].inc; // see RULE_01 see RULE_02 see RULE_08
						resid_r[p][k] <= step[p][k].resid;
					end
				end
			end
			assign phase_nxt[p] = acc_r[p][sel_q[p]]
				+ {cfg[p].phase[sel_q[p]], {(FREQ_W - PHASE_W){1'b0}}}; // see RULE_13
		end
	endgenerate

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			phase_a_o <= ACC_RST;
			phase_b_o <= ACC_RST;
			sel_a_o <= SEL_RST;
			sel_b_o <= SEL_RST;
		end else begin
			phase_a_o <= phase_nxt[0];
			phase_b_o <= phase_nxt[1];
			sel_a_o <= sel_q[0];
			sel_b_o <= sel_q[1];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Converter sample path.

	logic [ADC_LAT-1:0][SAMPLE_W-1:0] adc_pipe_r;

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			adc_pipe_r <= '0;
		end else begin
			adc_pipe_r <= {adc_pipe_r[ADC_LAT-2:0], sample_i}; // see RULE_04
		end
	end
	assign sample_o = adc_pipe_r[ADC_LAT-1];

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	logic [6:0] up_cnt_r;

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			up_cnt_r <= '0;
		end else if (up_cnt_r != UP_MAX) begin
			up_cnt_r <= up_cnt_r + 7'h01;
		end
	end

	AST_SOFT_SELECT: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see RULE_05
		(select_source_i != SRC_PINS) |-> (sel_now[0] == soft_select_a_i
		&& sel_now[1] == soft_select_b_i))
		else $error("soft selection not applied");

	AST_PIN_SELECT: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see RULE_06
		(select_source_i == SRC_PINS && $stable(hop_pin_a_msb_i) && $stable(hop_pin_a_lsb_i))
		##1 (select_source_i == SRC_PINS) |-> (sel_now[0] == {$past(hop_pin_a_msb_i),
		$past(hop_pin_a_lsb_i)}))
		else $error("pin selection decoded wrongly");

	AST_HOP_LATENCY: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see RULE_04
		(up_cnt_r == UP_MAX) |-> (sel_a_o == $past(sel_now[0], HOP_PIPE + 1)))
		else $error("hop latency wrong");

	AST_ADC_LATENCY: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see RULE_04
		(up_cnt_r == UP_MAX) |-> (sample_o == $past(sample_i, ADC_LAT)))
		else $error("sample latency wrong");

	AST_FREE_RUN: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see RULE_02
		(!sync_evt && rational_divider_i == RDIV_BASIC && sel_q[0] != 2'h3) |=>
		(acc_r[0][3] == $past(acc_r[0][3]) + $past(cfg_a_i.freq[3])))
		else $error("unselected accumulator stalled");

	AST_SYNC_CLEAR: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see RULE_21
		sync_evt |=> (acc_r[0] == '0 && acc_r[1] == '0))
		else $error("bank not cleared on sync");

	AST_SYNC_OFFSET: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see RULE_13
		(sync_evt && $stable(cfg_b_i.phase)) ##1 $stable(cfg_b_i.phase) |=>
		(phase_b_o == {$past(cfg_b_i.phase[sel_q[1]]), 16'h0000}))
		else $error("phase offset not applied after sync");

	AST_LINK_FIRE: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see RULE_18
		(sync_on_link_init_i && link_enable_i && $rose(link_sync_n_i)) |-> sync_evt
		##1 sync_event_o)
		else $error("link sync release missed");

	AST_REF_FIRE: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see RULE_20
		(armed_r && $rose(reference_i)) |-> sync_evt ##1 (!armed_r
		|| $past(sync_on_next_reference_i && !arm_q_r)))
		else $error("armed reference edge missed");

	AST_NO_SPURIOUS: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see RULE_15
		sync_evt |-> ((sync_on_link_init_i && link_enable_i) || armed_r))
		else $error("sync without trigger");

	AST_RESID_RANGE: assert property (@(posedge mclk_i) disable iff (!rstn_i) // see RULE_10
		(rational_divider_i != RDIV_BASIC && $stable(rational_divider_i)) |=>
		(resid_r[0][0] >= 0
		&& resid_r[0][0] < $signed({3'b000, $past(rational_divider_i)})))
		else $error("rational residue out of range");

endmodule : dnh_nco_bank

// ===== test/dnh_far_logic.sv
// Model of the external logic device that drives hop pins, link sync and reference.
`timescale 1ns/100ps
module dnh_far_logic
	import dnh_pkg::*;
(
	// Clock.
	input wire logic mclk_i,
	// Pins towards the oscillator bank.
	output dnh_hop_pins_t hop_a_o,
	output dnh_hop_pins_t hop_b_o,
	output logic link_sync_n_o,
	output logic reference_o
);
	initial begin
		hop_a_o = '0;
		hop_b_o = '0;
		link_sync_n_o = 1'b1;
		reference_o = 1'b0;
	end

	task automatic set_hop(input logic [SEL_W-1:0] a, input logic [SEL_W-1:0] b);
		hop_a_o = a;
		hop_b_o = b;
	endtask : set_hop

	// Sync is held low, then released high on one instant for every device.
	task automatic link_sync(input int low_cyc);
		@(posedge mclk_i);
		#1 link_sync_n_o = 1'b0;
		repeat (low_cyc) @(posedge mclk_i);
		#1 link_sync_n_o = 1'b1;
	endtask : link_sync

	// Reference rests low and gives a single pulse.
	task automatic ref_pulse(input int hi_cyc);
		@(posedge mclk_i);
		#1 reference_o = 1'b1;
		repeat (hi_cyc) @(posedge mclk_i);
		#1 reference_o = 1'b0;
	endtask : ref_pulse
endmodule : dnh_far_logic

// ===== test/dnh_nco_bank_test.sv
// Self-checking bench for the oscillator bank with hop selection.
`timescale 1ns/100ps
module dnh_nco_bank_test;
	import dnh_pkg::*;
	logic mclk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic select_source_i = 1'b0;
	logic [SEL_W-1:0] soft_select_a_i = '0;
	logic [SEL_W-1:0] soft_select_b_i = '0;
	dnh_path_cfg_t cfg_a_i = '0;
	dnh_path_cfg_t cfg_b_i = '0;
	logic [RDIV_W-1:0] rational_divider_i = '0;
	logic sync_on_link_init_i = 1'b0;
	logic sync_on_next_reference_i = 1'b0;
	logic link_enable_i = 1'b0;
	logic [SAMPLE_W-1:0] sample_i = '0;
	dnh_hop_pins_t pins_a;
	dnh_hop_pins_t pins_b;
	logic link_sync_n;
	logic reference;
	logic [FREQ_W-1:0] phase_a_o;
	logic [FREQ_W-1:0] phase_b_o;
	logic [SEL_W-1:0] sel_a_o;
	logic [SEL_W-1:0] sel_b_o;
	logic [SAMPLE_W-1:0] sample_o;
	logic sync_armed_o;
	logic sync_event_o;
	int err_count = 0;
	int n_checks = 0;
	int n_events = 0;
	int ev;
	logic [SAMPLE_W-1:0] hist[$];

	always #5 mclk_i = ~mclk_i;

	dnh_far_logic i_far (.mclk_i(mclk_i), .hop_a_o(pins_a), .hop_b_o(pins_b),
		.link_sync_n_o(link_sync_n), .reference_o(reference));

	dnh_nco_bank i_dut (.mclk_i(mclk_i), .rstn_i(rstn_i),
		.hop_pin_a_lsb_i(pins_a.lsb), .hop_pin_a_msb_i(pins_a.msb),
		.hop_pin_b_lsb_i(pins_b.lsb), .hop_pin_b_msb_i(pins_b.msb),
		.select_source_i(select_source_i), .soft_select_a_i(soft_select_a_i),
		.soft_select_b_i(soft_select_b_i), .cfg_a_i(cfg_a_i), .cfg_b_i(cfg_b_i),
		.rational_divider_i(rational_divider_i), .sync_on_link_init_i(sync_on_link_init_i),
		.sync_on_next_reference_i(sync_on_next_reference_i), .link_enable_i(link_enable_i),
		.link_sync_n_i(link_sync_n), .reference_i(reference), .sample_i(sample_i),
		.phase_a_o(phase_a_o), .phase_b_o(phase_b_o), .sel_a_o(sel_a_o), .sel_b_o(sel_b_o),
		.sample_o(sample_o), .sync_armed_o(sync_armed_o), .sync_event_o(sync_event_o));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [FREQ_W-1:0] seen, input logic [FREQ_W-1:0] exp,
		input string what);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic print_verdict;
		if (err_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : print_verdict

	// Phase after k increments from a sync, selected oscillator plus its offset.
	function automatic logic [FREQ_W-1:0] exp_phase(input dnh_path_cfg_t c,
		input logic [SEL_W-1:0] s, input int k, input logic [RDIV_W-1:0] r);
		logic [63:0] n;
		n = (64'(c.freq[s]) * r + 64'h0000_0000_0200_0000) >> RDIV_SHIFT;
		if (r == RDIV_BASIC)
			n = 64'(c.freq[s]) * 64'(k);
		else
			n = (n * 64'(k / r)) << RDIV_SHIFT;
		return n[FREQ_W-1:0] + {c.phase[s], 16'h0000};
	endfunction : exp_phase

	// Word that puts an oscillator on a whole number of rational steps.
	function automatic logic [FREQ_W-1:0] rat_word(input logic [RDIV_W-1:0] r, input int n);
		logic [63:0] w;
		w = ((64'(n) << (RDIV_SHIFT + 1)) + 64'(r)) / (64'(r) << 1);
		return w[FREQ_W-1:0];
	endfunction : rat_word

	// Waits for a sync event, then follows both phases while the soft selection moves.
	task automatic track(input int cycles);
		int m;
		m = -1;
		for (int w = 0; w < 20 && m < 0; w++) begin
			@(posedge mclk_i);
			#1 if (sync_event_o === 1'b1) m = 0;
		end
		check(m, 0, "no sync event");
		for (int k = 0; k < cycles; k++) begin
			@(posedge mclk_i);
			#1 if (rational_divider_i == RDIV_BASIC || k % rational_divider_i == 0) begin
				check(phase_a_o, exp_phase(cfg_a_i, sel_a_o, k, rational_divider_i), "phase a");
				check(phase_b_o, exp_phase(cfg_b_i, sel_b_o, k, rational_divider_i), "phase b");
			end
			if (k % 7 == 3) begin
				soft_select_a_i = 2'($urandom);
				soft_select_b_i = 2'($urandom);
			end
		end
	endtask : track

	// Moves the selection and checks it is not early and not late; the other source is noise.
	task automatic hop_lat(input logic [SEL_W-1:0] a, input logic [SEL_W-1:0] b, input int lat);
		logic [SEL_W-1:0] olda;
		logic [SEL_W-1:0] oldb;
		olda = sel_a_o;
		oldb = sel_b_o;
		if (select_source_i) begin
			i_far.set_hop(a, b);
			soft_select_a_i = 2'($urandom);
			soft_select_b_i = 2'($urandom);
		end else begin
			soft_select_a_i = a;
			soft_select_b_i = b;
			i_far.set_hop(2'($urandom), 2'($urandom));
		end
		repeat (lat - 2) @(posedge mclk_i);
		#1 check(sel_a_o, olda, "sel a early");
		check(sel_b_o, oldb, "sel b early");
		repeat (3) @(posedge mclk_i);
		#1 check(sel_a_o, a, "sel a");
		check(sel_b_o, b, "sel b");
	endtask : hop_lat

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge mclk_i) begin
		if (sync_event_o === 1'b1)
			n_events++;
	end

	always @(posedge mclk_i) begin
		#1 if (rstn_i !== 1'b1) hist.delete();
		else begin
			if (hist.size() >= ADC_LAT_CYC)
				check(sample_o, hist[hist.size() - ADC_LAT_CYC], "sample delay");
			sample_i = 12'($urandom);
			hist.push_back(sample_i);
		end
	end

	initial begin
		#50000;
		err_count++;
		print_verdict;
	end

	initial begin
		void'($urandom(32'h8d55aff8));
		repeat (3) @(posedge mclk_i);
		#1 check({sel_a_o, sel_b_o, sync_armed_o, sync_event_o}, '0, "reset outputs");
		check(phase_a_o, ACC_RST, "reset phase");
		rstn_i = 1'b1;
		for (int k = 0; k < NUM_OSC; k++) begin
			cfg_a_i.freq[k] = $urandom;
			cfg_b_i.freq[k] = $urandom;
			cfg_a_i.phase[k] = 16'($urandom);
			cfg_b_i.phase[k] = 16'($urandom);
		end
		cfg_a_i.freq[3] = 32'hffff_ffff;
		cfg_b_i.freq[0] = 32'h8000_0000;
		// Settings first, then the link-init enable, then a sync resynchronizes the words.
		link_enable_i = 1'b1;
		sync_on_link_init_i = 1'b1;
		fork
			i_far.link_sync(4);
			track(60);
		join
		select_source_i = SRC_PINS;
		// The change of source and the last soft moves drain out before a hop is timed.
		repeat (HOP_LAT_CYC) @(posedge mclk_i);
		#1 check({sel_a_o, sel_b_o}, '0, "pins at rest");
		repeat (4) hop_lat(sel_a_o + 2'd1, sel_b_o - 2'd1, HOP_LAT_CYC);
		select_source_i = 1'b0;
		repeat (4) hop_lat(sel_a_o + 2'd1, sel_b_o - 2'd1, HOP_LAT_CYC - 2);
		// Neither trigger fires while its enable is off.
		ev = n_events;
		link_enable_i = 1'b0;
		i_far.link_sync(2);
		repeat (2) @(posedge mclk_i);
		#1 link_enable_i = 1'b1;
		sync_on_link_init_i = 1'b0;
		i_far.link_sync(2);
		i_far.ref_pulse(2);
		repeat (5) @(posedge mclk_i);
		#1 check(n_events, ev, "unarmed sync");
		// An integral divider well below the advised ceiling, with words made to fit it.
		for (int k = 0; k < NUM_OSC; k++) begin
			cfg_a_i.freq[k] = rat_word(16'h0003, $urandom % 192);
			cfg_b_i.freq[k] = rat_word(16'h0003, $urandom % 192);
		end
		rational_divider_i = 16'h0003;
		sync_on_next_reference_i = 1'b1;
		repeat (3) @(posedge mclk_i);
		#1 check(sync_armed_o, 1'b1, "armed");
		fork
			i_far.ref_pulse(2);
			track(60);
		join
		check(sync_armed_o, 1'b0, "disarm after sync");
		print_verdict;
	end
endmodule : dnh_nco_bank_test
